// ===== verilog/lnb_fault_protection_control.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lnb_defines.svh"
module lnb_fault_protection_control #(
   // full-rate cycle counts; a bench may pass short ones
   parameter lnb_pkg::count_t LONG_CYC = `LNB_CNT_W'(`LNB_DLY_LONG_MS * `LNB_CYC_PER_MS),
   parameter lnb_pkg::count_t SHORT_CYC = `LNB_CNT_W'(`LNB_DLY_SHORT_MS * `LNB_CYC_PER_MS),
   parameter lnb_pkg::count_t OFF_CYC = `LNB_CNT_W'(`LNB_OFF_MS * `LNB_CYC_PER_MS)
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`LNB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`LNB_CH_N-1:0] overcurrentRaw,
   input wire logic supplyLowLockout,
   output logic lightLoadSinkEnable,
   output logic freqSelect,
   output logic compSelect,
   output logic [`LNB_CH_N-1:0] channelOn,
   output logic [`LNB_CH_N-1:0] limitBoostActive,
   output logic irqN,
   output logic regulatorEnable
);
   // address decode, used by read and write paths
   function automatic lnb_pkg::reg_sel_t regSel(input logic [`LNB_ADDR_W-1:0] a);
      case (a)
         `LNB_CTRL0_ADDR: regSel = lnb_pkg::SEL_CTRL0;
         `LNB_CTRL1_ADDR: regSel = lnb_pkg::SEL_CTRL1;
         `LNB_CTRL2_ADDR: regSel = lnb_pkg::SEL_CTRL2;
         `LNB_STAT_ADDR: regSel = lnb_pkg::SEL_STAT;
         default: regSel = lnb_pkg::SEL_NONE;
      endcase
   endfunction

   // two-flop synchronisers for the analog comparator levels
   logic [`LNB_CH_N:0] metaQ; // first stage, read only by second
   logic [`LNB_CH_N:0] syncQ; // safe copies
   logic [`LNB_CH_N-1:0] ocSync;
   logic lockSync;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         metaQ <= '0;
         syncQ <= '0;
      end else begin
         metaQ <= {supplyLowLockout, overcurrentRaw};
         syncQ <= metaQ;
      end
   end
   assign ocSync = syncQ[`LNB_CH_N-1:0];
   assign lockSync = syncQ[`LNB_CH_N];

   // bus phases
   lnb_pkg::reg_sel_t sel;
   logic setup, wrAcc, rdAcc, statRead;
   assign sel = regSel(paddr);
   assign setup = psel && !penable;
   assign wrAcc = psel && penable && pwrite && sel != lnb_pkg::SEL_NONE;
   assign rdAcc = psel && penable && !pwrite;
   assign statRead = rdAcc && sel == lnb_pkg::SEL_STAT; // the read that clears
   assign pready = 1'b1; // zero wait states
   assign pslverr = psel && penable && sel == lnb_pkg::SEL_NONE;

   // register state
   logic [7:0] ctrl0Q, ctrl0D; // application setup bits
   logic [`LNB_CH_N-1:0] chanEnQ, chanEnD; // host channel enables
   logic [`LNB_CH_N-1:0] boostEnQ, boostEnD; // limit boost arming
   logic [`LNB_CH_N-1:0] flagQ, flagD; // overcurrent fault flags
   logic irqNQ, irqND; // interrupt, low while pending
   logic [31:0] prdataQ, prdataD;
   logic [`LNB_CH_N-1:0] onQ, onD, boostOutQ, boostOutD;
   logic regEnQ, regEnD;
   logic [7:0] status;

   // channel timer links
   logic [`LNB_CH_N-1:0] tOn, tFault, tRestart, tBoost, tDone;

   genvar g;
   generate
      for (g = 0; g < `LNB_CH_N; g = g + 1) begin : gCh
         chan_if link();
         assign link.overcurrent = ocSync[g];
         assign link.delaySel = ctrl0Q[`LNB_DSEL_BIT];
         assign link.restartMode = ctrl0Q[`LNB_RMODE_BIT];
         assign link.boostReq = boostEnQ[g];
         assign link.reenable = wrAcc && sel == lnb_pkg::SEL_CTRL1 && pwdata[g];
         assign link.hold = lockSync;
         assign tOn[g] = link.outputOn;
         assign tFault[g] = link.faultPulse;
         assign tRestart[g] = link.restartPulse;
         assign tBoost[g] = link.boostActive;
         assign tDone[g] = link.boostDone;
         fault_timer #(
            .LONG_CYC(LONG_CYC),
            .SHORT_CYC(SHORT_CYC),
            .OFF_CYC(OFF_CYC)
         ) uTimer (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .ch(link.timer)
         );
      end
   endgenerate

   assign status = {~irqNQ, lockSync, boostOutQ, onQ, flagQ};

   // next values of the register file and outputs
   always_comb begin
      ctrl0D = ctrl0Q;
      chanEnD = chanEnQ;
      boostEnD = boostEnQ & ~tDone;
      flagD = flagQ;
      irqND = irqNQ;
      prdataD = prdataQ;
      // software writes
      if (wrAcc) begin
         case (sel)
            lnb_pkg::SEL_CTRL0: ctrl0D = pwdata[7:0];
            lnb_pkg::SEL_CTRL1: chanEnD = pwdata[`LNB_CH_N-1:0];
            lnb_pkg::SEL_CTRL2: boostEnD = pwdata[`LNB_CH_N-1:0];
            default: ;
         endcase
      end
      // read clears first, hardware events override after
      if (statRead) begin
         irqND = 1'b1;
         if (!ctrl0Q[`LNB_RMODE_BIT]) begin
            flagD = '0;
         end
      end
      flagD = flagD & ~tRestart;
      flagD = flagD | tFault;
      if (|tFault) begin
         irqND = 1'b0;
      end
      // read data captured in the setup phase
      if (setup && !pwrite) begin
         case (sel)
            lnb_pkg::SEL_CTRL0: prdataD = {24'h000000, ctrl0Q};
            lnb_pkg::SEL_CTRL1: prdataD = {30'h0, chanEnQ};
            lnb_pkg::SEL_CTRL2: prdataD = {30'h0, boostEnQ};
            lnb_pkg::SEL_STAT: prdataD = {24'h000000, status};
            default: prdataD = 32'h00000000;
         endcase
      end
      // lockout wipes all control registers
      if (lockSync) begin
         ctrl0D = `LNB_CTRL_RST;
         chanEnD = '0;
         boostEnD = '0;
      end
      onD = chanEnQ & tOn & {`LNB_CH_N{!lockSync}};
      boostOutD = tBoost & onD;
      regEnD = !lockSync;
   end

   // registers only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl0Q <= `LNB_CTRL_RST;
         chanEnQ <= '0;
         boostEnQ <= '0;
         flagQ <= '0;
         irqNQ <= 1'b1;
         prdataQ <= 32'h00000000;
         onQ <= '0;
         boostOutQ <= '0;
         regEnQ <= 1'b0;
      end else begin
         ctrl0Q <= ctrl0D;
         chanEnQ <= chanEnD;
         boostEnQ <= boostEnD;
         flagQ <= flagD;
         irqNQ <= irqND;
         prdataQ <= prdataD;
         onQ <= onD;
         boostOutQ <= boostOutD;
         regEnQ <= regEnD;
      end
   end

   // configuration pins straight from control register 0
   assign lightLoadSinkEnable = ctrl0Q[`LNB_SINK_BIT];
   assign freqSelect = ctrl0Q[`LNB_FREQ_BIT];
   assign compSelect = ctrl0Q[`LNB_COMP_BIT];
   assign channelOn = onQ;
   assign limitBoostActive = boostOutQ;
   assign irqN = irqNQ;
   assign regulatorEnable = regEnQ;
   assign prdata = prdataQ;

   a_sink_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wrAcc && sel == lnb_pkg::SEL_CTRL0 && !lockSync |=> lightLoadSinkEnable == $past(pwdata[7]))
      else $error("sink enable not written");
   a_irq_on_fault: assert property (@(posedge core_clk) disable iff (!reset_n)
      |tFault |=> !irqN && (flagQ & $past(tFault)) == $past(tFault))
      else $error("fault did not flag");
   a_read_releases: assert property (@(posedge core_clk) disable iff (!reset_n)
      statRead && !(|tFault) |=> irqN) else $error("read kept interrupt");
   a_latch_read_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      statRead && !ctrl0Q[`LNB_RMODE_BIT] && !(|tFault) |=> flagQ == '0)
      else $error("latch flag survived read");
   // every channel watched, so whichever one restarts is covered
   a_restart_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      |(tRestart & ~tFault) |=> (flagQ & $past(tRestart & ~tFault)) == '0)
      else $error("hiccup flag kept");
   a_boost_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      |tDone && !(wrAcc && sel == lnb_pkg::SEL_CTRL2) |=> (boostEnQ & $past(tDone)) == '0)
      else $error("boost bit not cleared");
   a_lock_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      lockSync |=> !regulatorEnable && channelOn == '0 && ctrl0Q == `LNB_CTRL_RST)
      else $error("lockout left regulator on");
   a_sync_delay: assert property (@(posedge core_clk) disable iff (!reset_n)
      supplyLowLockout ##1 supplyLowLockout |-> ##1 lockSync)
      else $error("lockout sync too slow");
   c_fault: cover property (@(posedge core_clk) disable iff (!reset_n) |tFault);
   c_restart: cover property (@(posedge core_clk) disable iff (!reset_n) |tRestart);
   c_boost_done: cover property (@(posedge core_clk) disable iff (!reset_n) |tDone);
endmodule

// ===== common/lnb_defines.svh
`ifndef LNB_DEFINES_SVH
`define LNB_DEFINES_SVH
// core clock rate and derived cycles per millisecond
`define LNB_CLK_HZ 40000000
`define LNB_CYC_PER_MS (`LNB_CLK_HZ / 1000)
// overcurrent delays and hiccup off time, in ms
`define LNB_DLY_LONG_MS 45
`define LNB_DLY_SHORT_MS 28
`define LNB_OFF_MS 1000
// timer width, enough for the 1 s off time
`define LNB_CNT_W 26
`define LNB_CH_N 2
// register byte addresses on the bus
`define LNB_ADDR_W 8
`define LNB_CTRL0_ADDR 8'h00
`define LNB_CTRL1_ADDR 8'h04
`define LNB_CTRL2_ADDR 8'h08
`define LNB_STAT_ADDR 8'h0C
// control register 0 fields
`define LNB_SINK_BIT 7
`define LNB_COMP_BIT 5
`define LNB_FREQ_BIT 4
`define LNB_DSEL_BIT 3
`define LNB_RMODE_BIT 2
// status register fields
`define LNB_ST_FLAG_LSB 0
`define LNB_ST_ON_LSB 2
`define LNB_ST_BOOST_LSB 4
`define LNB_ST_LOCK_BIT 6
`define LNB_ST_IRQ_BIT 7
// reset value of control register 0, also loaded in lockout
`define LNB_CTRL_RST 8'h00
`endif

// ===== common/lnb_pkg.sv
`include "lnb_defines.svh"
package lnb_pkg;
   // per-channel protection timer states
   typedef enum logic [1:0] {RUN, HICCUP, LATCHED} timer_state_t;
   // register decode result
   typedef enum logic [2:0] {SEL_CTRL0, SEL_CTRL1, SEL_CTRL2, SEL_STAT, SEL_NONE} reg_sel_t;
   typedef logic [`LNB_CNT_W-1:0] count_t;
endpackage

// ===== common/chan_if.sv
`timescale 1ns/1ps
// control side to one channel timer
interface chan_if;
   logic overcurrent; // synced overcurrent level
   logic delaySel; // long delay when high
   logic restartMode; // hiccup when high, latch when low
   logic boostReq; // limit boost armed by software
   logic reenable; // one-cycle restart after latch
   logic hold; // lockout, forces timer idle
   logic outputOn; // channel allowed to run
   logic faultPulse; // delay expired, output cut
   logic restartPulse; // hiccup off time over
   logic boostActive; // limit raised now
   logic boostDone; // quarter delay spent
   modport ctrl(output overcurrent, delaySel, restartMode, boostReq, reenable, hold,
      input outputOn, faultPulse, restartPulse, boostActive, boostDone);
   modport timer(input overcurrent, delaySel, restartMode, boostReq, reenable, hold,
      output outputOn, faultPulse, restartPulse, boostActive, boostDone);
endinterface

// ===== verilog/fault_timer.sv
`timescale 1ns/1ps
`include "lnb_defines.svh"
module fault_timer #(
   parameter lnb_pkg::count_t LONG_CYC = '1,
   parameter lnb_pkg::count_t SHORT_CYC = '1,
   parameter lnb_pkg::count_t OFF_CYC = '1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   chan_if.timer ch
);
   lnb_pkg::timer_state_t stateQ, stateD; // protection state
   lnb_pkg::count_t cntQ, cntD; // shared delay/off counter
   lnb_pkg::count_t limit; // active overcurrent delay
   lnb_pkg::count_t quarter; // boost window length
   logic onQ, onD, faultQ, faultD, restartQ, restartD;
   logic boostQ, boostD, doneQ, doneD;

   assign limit = ch.delaySel ? LONG_CYC : SHORT_CYC;
   assign quarter = limit >> 2;

   // next state; one counter serves delay and off time
   always_comb begin
      stateD = stateQ;
      cntD = cntQ;
      faultD = 1'b0;
      restartD = 1'b0;
      case (stateQ)
         lnb_pkg::RUN: begin
            if (!ch.overcurrent) begin
               cntD = '0;
            end else if (cntQ >= limit - 1'b1) begin
               faultD = 1'b1;
               cntD = '0;
               stateD = ch.restartMode ? lnb_pkg::HICCUP : lnb_pkg::LATCHED;
            end else begin
               cntD = cntQ + 1'b1;
            end
         end
         lnb_pkg::HICCUP: begin
            if (cntQ >= OFF_CYC - 1'b1) begin
               restartD = 1'b1;
               cntD = '0;
               stateD = lnb_pkg::RUN;
            end else begin
               cntD = cntQ + 1'b1;
            end
         end
         lnb_pkg::LATCHED: begin
            if (ch.reenable) begin
               stateD = lnb_pkg::RUN;
            end
         end
         default: begin
            stateD = lnb_pkg::RUN;
            cntD = '0;
         end
      endcase
      // lockout parks the timer, nothing pending survives
      if (ch.hold) begin
         stateD = lnb_pkg::RUN;
         cntD = '0;
         faultD = 1'b0;
         restartD = 1'b0;
      end
      onD = (stateD == lnb_pkg::RUN);
      // boost from event start until a quarter delay has run
      // keyed on the current count so the raised limit lasts the whole quarter
      boostD = ch.boostReq && stateD == lnb_pkg::RUN && ch.overcurrent && cntQ < quarter;
      doneD = ch.boostReq && stateQ == lnb_pkg::RUN && ch.overcurrent && cntQ == quarter - 1'b1;
   end

   // registers only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stateQ <= lnb_pkg::RUN;
         cntQ <= '0;
         onQ <= 1'b0;
         faultQ <= 1'b0;
         restartQ <= 1'b0;
         boostQ <= 1'b0;
         doneQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         cntQ <= cntD;
         onQ <= onD;
         faultQ <= faultD;
         restartQ <= restartD;
         boostQ <= boostD;
         doneQ <= doneD;
      end
   end

   assign ch.outputOn = onQ;
   assign ch.faultPulse = faultQ;
   assign ch.restartPulse = restartQ;
   assign ch.boostActive = boostQ;
   assign ch.boostDone = doneQ;

   a_fault_cuts_out: assert property (@(posedge core_clk) disable iff (!reset_n)
      ch.faultPulse |-> !ch.outputOn) else $error("output on after fault");
   a_restart_turns_on: assert property (@(posedge core_clk) disable iff (!reset_n)
      ch.restartPulse |-> ch.outputOn && $past(stateQ) == lnb_pkg::HICCUP)
      else $error("restart without hiccup");
   a_latch_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
      stateQ == lnb_pkg::LATCHED && !ch.reenable && !ch.hold |=> !ch.outputOn)
      else $error("latched channel came back");
   a_timer_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
      stateQ == lnb_pkg::RUN && !ch.overcurrent |=> cntQ == '0)
      else $error("delay timer not reset");
   c_latch: cover property (@(posedge core_clk) disable iff (!reset_n)
      stateQ == lnb_pkg::LATCHED ##1 ch.reenable);
endmodule

// ===== tb/load_model.sv
`timescale 1ns/1ps
// far side: converter load, draws overload current only while powered
module load_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] channelOn,
   input wire logic [1:0] shortReq,
   output logic [1:0] overcurrentRaw
);
   // a dead output cannot draw current, so the comparator falls when cut
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         overcurrentRaw <= 2'h0;
      end else begin
         overcurrentRaw <= shortReq & channelOn;
      end
   end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   // shortened counts: long, short delay and off time
   localparam int LC = 40;
   localparam int SC = 24;
   localparam int OC = 100;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic supplyLowLockout = 1'b0;
   logic [1:0] shortReq = 2'h0; // short applied at each output
   logic [31:0] prdata;
   logic pready, pslverr, irqN, regulatorEnable;
   logic lightLoadSinkEnable, freqSelect, compSelect;
   logic [1:0] channelOn, limitBoostActive, overcurrentRaw;
   wire logic [3:0] obs = {limitBoostActive, channelOn}; // watched levels
   int miscompares = 0;
   int testsRun = 0;
   int k;
   logic [32:0] expQ[$]; // expected {pslverr, prdata} per read
   logic [31:0] rng = 32'h2;
   logic [31:0] v;

   lnb_fault_protection_control #(.LONG_CYC(lnb_pkg::count_t'(LC)), .SHORT_CYC(lnb_pkg::count_t'(SC)),
      .OFF_CYC(lnb_pkg::count_t'(OC))) u_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .overcurrentRaw(overcurrentRaw),
      .supplyLowLockout(supplyLowLockout), .lightLoadSinkEnable(lightLoadSinkEnable),
      .freqSelect(freqSelect), .compSelect(compSelect), .channelOn(channelOn),
      .limitBoostActive(limitBoostActive), .irqN(irqN), .regulatorEnable(regulatorEnable));
   load_model u_load (.core_clk(core_clk), .reset_n(reset_n), .channelOn(channelOn),
      .shortReq(shortReq), .overcurrentRaw(overcurrentRaw));

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   // xorshift source, seeded at 2
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one apb transfer, entered just after a rising edge; reads note their expectation
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      if (!w) begin
         expQ.push_back(e);
      end
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask

   // counts falling edges until a watched level reaches v, bounded
   task automatic waitOn(input int i, input logic v, output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (obs[i] !== v && n < 2000);
      // a wait that runs out is a failure, not a silent pass
      if (n >= 2000) begin
         miscompares++;
         $display("BAD wait level expected %h seen %h", v, obs[i]);
      end
      @(posedge core_clk);
   endtask

   // read completions taken off the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check("read", {pslverr, prdata}, expQ.pop_front());
      end
   end

   // watchdog well beyond the expected run of under a thousand cycles
   initial begin
      #750000;
      miscompares++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd(8'h00, 33'h0);
      rd(8'h08, 33'h0);
      wr(8'h0C, 32'hFF);
      rd(8'h0C, 33'h0);
      rd(8'h10, {1'b1, 32'h0});
      // config pins follow ctrl0 bits
      repeat (4) begin
         v = xs() & 32'hFF;
         wr(8'h00, v);
         rd(8'h00, {1'b0, v});
         @(negedge core_clk);
         check("sink", lightLoadSinkEnable, v[7]);
         check("comp", compSelect, v[5]);
         check("freq", freqSelect, v[4]);
         @(posedge core_clk);
      end
      // latch mode, short delay
      wr(8'h00, xs() & 32'hB0);
      wr(8'h04, 32'h1);
      repeat (3) @(posedge core_clk);
      shortReq <= 2'h1;
      waitOn(0, 1'b0, k);
      check("short delay", k >= SC + 1 && k <= SC + 8, 1'b1);
      @(negedge core_clk);
      check("irq low", irqN, 1'b0);
      @(posedge core_clk);
      shortReq <= 2'h0;
      rd(8'h0C, 33'h81);
      @(negedge core_clk);
      check("irq freed", irqN, 1'b1);
      @(posedge core_clk);
      rd(8'h0C, 33'h0);
      repeat (OC + 10) @(posedge core_clk);
      @(negedge core_clk);
      check("latched", channelOn, 2'h0);
      @(posedge core_clk);
      wr(8'h04, 32'h1);
      waitOn(0, 1'b1, k);
      check("reenable", k <= 4, 1'b1);
      // hiccup mode, long delay; setup bits change only with outputs off
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0C);
      wr(8'h04, 32'h3);
      repeat (3) @(posedge core_clk);
      shortReq <= 2'h2;
      waitOn(1, 1'b0, k);
      check("long delay", k >= LC + 1 && k <= LC + 8, 1'b1);
      waitOn(1, 1'b1, k);
      check("off time", k >= OC - 1 && k <= OC + 6, 1'b1);
      rd(8'h0C, 33'h8C);
      waitOn(1, 1'b0, k);
      check("retry", k >= LC - 4 && k <= LC + 8, 1'b1);
      shortReq <= 2'h0;
      rd(8'h0C, 33'h86);
      waitOn(1, 1'b1, k);
      repeat (60) @(posedge core_clk);
      rd(8'h0C, 33'h0C);
      // quarter-delay limit boost, then self-clear
      wr(8'h08, 32'h1);
      shortReq <= 2'h1;
      waitOn(2, 1'b1, k);
      waitOn(2, 1'b0, k);
      check("boost span", k >= LC / 4 && k <= LC / 4 + 1, 1'b1);
      rd(8'h08, 33'h0);
      waitOn(0, 1'b0, k);
      shortReq <= 2'h0;
      waitOn(0, 1'b1, k);
      // lockout parks everything and clears setup
      supplyLowLockout <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check("lockout", {regulatorEnable, channelOn}, 3'h0);
      @(posedge core_clk);
      supplyLowLockout <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(8'h00, 33'h0);
      rd(8'h04, 33'h0);
      @(negedge core_clk);
      check("regulator on", regulatorEnable, 1'b1);
      @(posedge core_clk);
      wrap_up();
   end
endmodule
